// *** rtl/flash_ctrl.sv ***
// Flash program and erase controller with a classic Wishbone slave.
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
`include "flash_ctrl_map.svh"
module flash_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter logic [15:0] PAGE_ERASE_US = `PAGE_ERASE_TIME_US,
    parameter logic [15:0] MASS_ERASE_US = `MASS_ERASE_TIME_US
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [13:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Access qualifier and option bits
    input wire logic i_debug_access,
    input wire logic i_read_protect_option,
    input wire logic i_write_protect_option,
    input wire logic i_high_sector_write_lock_option,
    // Flash array
    output logic [12:0] o_flash_addr,
    output logic [7:0] o_flash_wdata,
    output logic o_flash_prog,
    output logic o_flash_page_erase,
    output logic o_flash_mass_erase,
    input wire logic [7:0] i_flash_rdata,
    // Processor hold
    output logic o_cpu_hold
);
    ctrl_state_t state_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0] page_select_reg;
    logic [6:0] active_page_reg;
    logic [7:0] sector_lock_reg;
    logic [15:0] clock_khz_reg;
    logic [15:0] prog_addr_reg;
    logic [16:0] us_acc_reg;
    logic [15:0] us_left_reg;
    logic [12:0] flash_addr_reg;
    logic [7:0] flash_wdata_reg;
    logic prog_reg;
    logic page_erase_reg;
    logic mass_erase_reg;
    logic hold_reg;
    logic access;
    logic wr;
    logic rd;
    logic [11:0] idx;
    logic [7:0] wdata;
    logic cmd_wr;
    logic page_wr;
    logic data_wr;
    logic [16:0] us_acc_next;
    logic us_tick;
    logic user_write_ok;
    logic page_erase_ok;
    logic prog_ok;
    logic [5:0] status_code;

    assign access = i_wb_cyc & i_wb_stb & ~ack_reg;
    assign wr = access & i_wb_we & i_wb_sel[0];
    assign rd = access & ~i_wb_we;
    assign idx = i_wb_adr[13:2];
    assign wdata = i_wb_dat[7:0];
    assign cmd_wr = wr & (idx == `IDX_COMMAND);
    assign page_wr = wr & (idx == `IDX_PAGE_SELECT);
    assign data_wr = wr & (idx == `IDX_PROG_DATA);

    // The high-sector option is never used; of the option bits only the write option gates user writes.
    assign user_write_ok = i_write_protect_option;
    assign page_erase_ok = i_debug_access | (user_write_ok
        & ~sector_lock_reg[active_page_reg[3:1]]);
    assign prog_ok = i_debug_access | (user_write_ok
        & (prog_addr_reg[15:9] == active_page_reg)
        & ~sector_lock_reg[prog_addr_reg[12:10]]);

    always_comb begin
        unique case (state_reg)
            ST_LOCKED: status_code = `STAT_LOCKED;
            ST_FIRST: status_code = `STAT_FIRST;
            ST_SECOND: status_code = `STAT_SECOND;
            ST_UNLOCKED: status_code = `STAT_UNLOCKED;
            ST_SECTOR: status_code = `STAT_SECTOR;
            ST_PROG: status_code = `STAT_PROG;
            ST_PAGE_ERASE: status_code = `STAT_PAGE_ERASE;
            ST_MASS_ERASE: status_code = `STAT_MASS_ERASE;
            default: status_code = `STAT_LOCKED;
        endcase
    end

    // Bus answer: one wait state, unmapped reads return zero.
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= access;
            if (rd) begin
                rdata_reg <= 32'h0000_0000;
                unique case (idx)
                    `IDX_COMMAND: rdata_reg[5:0] <= status_code;
                    `IDX_PAGE_SELECT: rdata_reg[7:0] <= (state_reg ==
                        ST_SECTOR) ? sector_lock_reg : page_select_reg;
                    `IDX_CLOCK_KHZ_HI: rdata_reg[7:0] <= clock_khz_reg[15:8];
                    `IDX_CLOCK_KHZ_LO: rdata_reg[7:0] <= clock_khz_reg[7:0];
                    `IDX_PROG_ADDR: rdata_reg[15:0] <= prog_addr_reg;
                    `IDX_PROG_DATA: begin
                        if (!(i_debug_access && i_read_protect_option)) begin
                            rdata_reg[7:0] <= i_flash_rdata;
                        end
                    end
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Clock value and program address registers.
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            clock_khz_reg <= `RST_KHZ;
            prog_addr_reg <= {`RST_BYTE, `RST_BYTE};
        end else if (wr) begin
            if (idx == `IDX_CLOCK_KHZ_HI) begin
                clock_khz_reg[15:8] <= wdata;
            end
            if (idx == `IDX_CLOCK_KHZ_LO) begin
                clock_khz_reg[7:0] <= wdata;
            end
            if (idx == `IDX_PROG_ADDR) begin
                prog_addr_reg <= i_wb_dat[15:0];
            end
        end
    end

    // Microsecond tick from the kHz value; below 1 MHz one tick per cycle
    // is the most, so operations only ever run longer than asked.
    // The accumulator is then cleared on each tick so that it cannot wrap.
    assign us_acc_next = us_acc_reg + `US_PER_MS;
    assign us_tick = (us_acc_next >= {1'b0, clock_khz_reg});

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            us_acc_reg <= 17'h0_0000;
        end else if (us_tick && {1'b0, clock_khz_reg} < `US_PER_MS) begin
            us_acc_reg <= 17'h0_0000;
        end else if (us_tick) begin
            us_acc_reg <= us_acc_next - {1'b0, clock_khz_reg};
        end else begin
            us_acc_reg <= us_acc_next;
        end
    end

    // Controller sequence, protection and flash strobes.
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_reg <= ST_LOCKED;
            page_select_reg <= `RST_BYTE;
            active_page_reg <= 7'h00;
            sector_lock_reg <= `RST_BYTE;
            us_left_reg <= 16'h0000;
            flash_addr_reg <= 13'h0000;
            flash_wdata_reg <= `ERASED_BYTE;
            prog_reg <= 1'b0;
            page_erase_reg <= 1'b0;
            mass_erase_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_LOCKED: begin
                    if (cmd_wr && wdata == `CMD_UNLOCK_FIRST) begin
                        state_reg <= ST_FIRST;
                    end
                    if (page_wr) begin
                        page_select_reg <= wdata;
                    end
                end
                ST_FIRST: begin
                    if (cmd_wr) begin
                        if (wdata == `CMD_UNLOCK_SECOND
                            && i_debug_access) begin
                            state_reg <= ST_UNLOCKED;
                            active_page_reg <= page_select_reg[6:0];
                        end else if (wdata == `CMD_UNLOCK_SECOND) begin
                            state_reg <= ST_SECOND;
                        end else if (wdata == `CMD_SECTOR_ACCESS) begin
                            state_reg <= ST_SECTOR;
                        end else begin
                            state_reg <= ST_LOCKED;
                        end
                    end else if (page_wr) begin
                        page_select_reg <= wdata;
                    end
                end
                ST_SECOND: begin
                    if (cmd_wr) begin
                        state_reg <= ST_LOCKED;
                    end else if (page_wr && wdata == page_select_reg) begin
                        state_reg <= ST_UNLOCKED;
                        active_page_reg <= wdata[6:0];
                    end else if (page_wr) begin
                        state_reg <= ST_LOCKED;
                        page_select_reg <= wdata;
                    end
                end
                ST_SECTOR: begin
                    if (page_wr) begin
                        sector_lock_reg <= i_debug_access ? wdata
                            : (sector_lock_reg | wdata);
                        state_reg <= ST_LOCKED;
                    end else if (cmd_wr) begin
                        state_reg <= ST_LOCKED;
                    end
                end
                ST_UNLOCKED: begin
                    if (cmd_wr) begin
                        if (wdata == `CMD_PAGE_ERASE && page_erase_ok) begin
                            state_reg <= ST_PAGE_ERASE;
                            page_erase_reg <= 1'b1;
                            hold_reg <= 1'b1;
                            flash_addr_reg <= {active_page_reg[3:0], 9'h000};
                            us_left_reg <= PAGE_ERASE_US;
                        end else if (wdata == `CMD_MASS_ERASE
                            && i_debug_access) begin
                            state_reg <= ST_MASS_ERASE;
                            mass_erase_reg <= 1'b1;
                            hold_reg <= 1'b1;
                            us_left_reg <= MASS_ERASE_US;
                        end else begin
                            state_reg <= ST_LOCKED;
                        end
                    end else if (page_wr && i_debug_access) begin
                        page_select_reg <= wdata;
                        active_page_reg <= wdata[6:0];
                    end else if (data_wr && prog_ok) begin
                        state_reg <= ST_PROG;
                        prog_reg <= 1'b1;
                        hold_reg <= 1'b1;
                        flash_addr_reg <= prog_addr_reg[12:0];
                        // The array only pulls bits low; ones are left alone.
                        flash_wdata_reg <= wdata;
                        us_left_reg <= `PROG_TIME_US;
                    end
                end
                ST_PROG, ST_PAGE_ERASE, ST_MASS_ERASE: begin
                    if (us_tick && us_left_reg != 16'h0000) begin
                        us_left_reg <= us_left_reg - 16'h0001;
                    end
                    if (us_left_reg == 16'h0000) begin
                        prog_reg <= 1'b0;
                        page_erase_reg <= 1'b0;
                        mass_erase_reg <= 1'b0;
                        hold_reg <= 1'b0;
                        flash_wdata_reg <= `ERASED_BYTE;
                        // The page stays open after a byte; erases relock.
                        state_reg <= (state_reg == ST_PROG) ? ST_UNLOCKED
                            : ST_LOCKED;
                    end
                end
                default: state_reg <= ST_LOCKED;
            endcase
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdata_reg;
    assign o_flash_addr = flash_addr_reg;
    assign o_flash_wdata = flash_wdata_reg;
    assign o_flash_prog = prog_reg;
    assign o_flash_page_erase = page_erase_reg;
    assign o_flash_mass_erase = mass_erase_reg;
    assign o_cpu_hold = hold_reg;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    property p_reset_locks;
        $fell(i_reset) |-> state_reg == ST_LOCKED && !o_cpu_hold;
    endproperty
    a_reset_locks: assert property (p_reset_locks)
        else $error("controller not locked after reset");

    property p_page_mismatch;
        state_reg == ST_SECOND && page_wr && !cmd_wr
            && wdata != page_select_reg |=> state_reg == ST_LOCKED;
    endproperty
    a_page_mismatch: assert property (p_page_mismatch)
        else $error("mismatched page select did not lock");

    property p_protected_erase;
        state_reg == ST_UNLOCKED && cmd_wr && wdata == `CMD_PAGE_ERASE
            && !page_erase_ok |=> !o_flash_page_erase [*2];
    endproperty
    a_protected_erase: assert property (p_protected_erase)
        else $error("protected page was erased");

    property p_other_cmd_locks;
        state_reg == ST_UNLOCKED && cmd_wr && wdata != `CMD_PAGE_ERASE
            && wdata != `CMD_MASS_ERASE |=> state_reg == ST_LOCKED;
    endproperty
    a_other_cmd_locks: assert property (p_other_cmd_locks)
        else $error("stray command did not lock");

    property p_user_no_mass;
        cmd_wr && !i_debug_access |=> !$rose(o_flash_mass_erase);
    endproperty
    a_user_no_mass: assert property (p_user_no_mass)
        else $error("user code started a mass erase");

    property p_lock_sticky;
        !i_debug_access |=> (sector_lock_reg & $past(sector_lock_reg))
            == $past(sector_lock_reg);
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("sector lock bit cleared by user code");

    property p_sector_select;
        state_reg == ST_FIRST && cmd_wr && wdata == `CMD_SECTOR_ACCESS
            |=> state_reg == ST_SECTOR ##1 status_code == `STAT_SECTOR
            || state_reg != ST_SECTOR;
    endproperty
    a_sector_select: assert property (p_sector_select)
        else $error("sector access sequence not taken");

    property p_erase_relocks;
        $fell(o_flash_page_erase) |-> state_reg == ST_LOCKED;
    endproperty
    a_erase_relocks: assert property (p_erase_relocks)
        else $error("page erase did not relock");

    property p_no_write_option;
        data_wr && state_reg == ST_UNLOCKED && !i_debug_access
            && !i_write_protect_option |=> !o_flash_prog;
    endproperty
    a_no_write_option: assert property (p_no_write_option)
        else $error("program with write option clear");

    property p_read_protect;
        rd && idx == `IDX_PROG_DATA && i_debug_access
            && i_read_protect_option |=> o_wb_dat == 32'h0000_0000;
    endproperty
    a_read_protect: assert property (p_read_protect)
        else $error("protected flash read by debugger");

    property p_hold_busy;
        o_flash_prog || o_flash_page_erase || o_flash_mass_erase
            |-> o_cpu_hold;
    endproperty
    a_hold_busy: assert property (p_hold_busy)
        else $error("processor not held during operation");

    c_program: cover property ($fell(o_flash_prog));
    c_page_erase: cover property ($fell(o_flash_page_erase));
    c_mass_erase: cover property ($fell(o_flash_mass_erase));
endmodule : flash_ctrl

// *** shared/flash_ctrl_map.svh ***
// Register indices, command codes, status codes and timing constants.
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
// Register indices; the byte address is four times the index.
`define IDX_COMMAND 12'h0FF8
`define IDX_PAGE_SELECT 12'h0FF9
`define IDX_CLOCK_KHZ_HI 12'h0FFA
`define IDX_CLOCK_KHZ_LO 12'h0FFB
`define IDX_PROG_ADDR 12'h0FFC
`define IDX_PROG_DATA 12'h0FFD
// Command codes.
`define CMD_UNLOCK_FIRST 8'h73
`define CMD_UNLOCK_SECOND 8'h8C
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63
`define CMD_SECTOR_ACCESS 8'h5E
// Controller state codes.
`define STAT_LOCKED 6'h00
`define STAT_FIRST 6'h01
`define STAT_SECOND 6'h02
`define STAT_UNLOCKED 6'h03
`define STAT_SECTOR 6'h04
`define STAT_PROG 6'h08
`define STAT_PAGE_ERASE 6'h10
`define STAT_MASS_ERASE 6'h20
// Reset values.
`define RST_BYTE 8'h00
`define RST_KHZ 16'h0000
`define ERASED_BYTE 8'hFF
// Operation times in microseconds.
`define PROG_TIME_US 16'd40
`define PAGE_ERASE_TIME_US 16'd10000
`define MASS_ERASE_TIME_US 16'd20000
// Microseconds per millisecond, used with the kHz clock value.
`define US_PER_MS 17'd1000
`endif

// *** shared/flash_ctrl_pkg.sv ***
// Types shared by the flash program and erase controller.
package flash_ctrl_pkg;
    typedef enum logic [7:0] {
        ST_LOCKED = 8'b0000_0001,
        ST_FIRST = 8'b0000_0010,
        ST_SECOND = 8'b0000_0100,
        ST_UNLOCKED = 8'b0000_1000,
        ST_SECTOR = 8'b0001_0000,
        ST_PROG = 8'b0010_0000,
        ST_PAGE_ERASE = 8'b0100_0000,
        ST_MASS_ERASE = 8'b1000_0000
    } ctrl_state_t;
endpackage : flash_ctrl_pkg

// *** tb/flash_array_model.sv ***
// Behavioural model of the flash array behind the controller.
`timescale 1ns/1ns
module flash_array_model (
    // Clock
    input wire logic i_clock,
    // Controller side
    input wire logic [12:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_prog,
    input wire logic i_page_erase,
    input wire logic i_mass_erase,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:8191];
    logic prog_reg, page_reg, mass_reg;

    // The array starts erased so that every later value is a real write.
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'hFF;
        end
        prog_reg = 1'b0;
        page_reg = 1'b0;
        mass_reg = 1'b0;
    end

    // Each operation acts once, on the rising edge of its strobe.
    always @(posedge i_clock) begin
        prog_reg <= i_prog;
        page_reg <= i_page_erase;
        mass_reg <= i_mass_erase;
        if (i_prog && !prog_reg) begin
            mem[i_addr] <= mem[i_addr] & i_wdata;
        end
        if (i_page_erase && !page_reg) begin
            for (int i = 0; i < 512; i++) begin
                mem[{i_addr[12:9], i[8:0]}] <= 8'hFF;
            end
        end
        if (i_mass_erase && !mass_reg) begin
            for (int i = 0; i < 8192; i++) begin
                mem[i] <= 8'hFF;
            end
        end
    end

    assign o_rdata = mem[i_addr];
endmodule : flash_array_model

// *** tb/tb_top.sv ***
// Self-checking bench for the flash program and erase controller.
`timescale 1ns/1ns
`include "flash_ctrl_map.svh"
module tb_top;
    logic clock, reset, cyc, stb, we, dbg, rprot, wprot, hsw, ack, hold;
    logic [13:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, junk;
    logic [12:0] faddr;
    logic [7:0] fwdata, frdata;
    logic fprog, fpage, fmass;
    int failures = 0;
    int samples_checked = 0;
    // Clock cycles per microsecond at the 20 MHz bench clock.
    localparam int CYCLES_PER_US = 20;

    // Short erase times keep the run brief; the kHz value loaded is the
    // real clock, so timing runs at the rate a user would see.
    flash_ctrl #(.PAGE_ERASE_US(16'h0004), .MASS_ERASE_US(16'h0006)) DUT (
        .i_clock(clock), .i_reset(reset), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_debug_access(dbg),
        .i_read_protect_option(rprot), .i_write_protect_option(wprot),
        .i_high_sector_write_lock_option(hsw), .o_flash_addr(faddr),
        .o_flash_wdata(fwdata), .o_flash_prog(fprog),
        .o_flash_page_erase(fpage), .o_flash_mass_erase(fmass),
        .i_flash_rdata(frdata), .o_cpu_hold(hold));

    flash_array_model far_array (
        .i_clock(clock), .i_addr(faddr), .i_wdata(fwdata), .i_prog(fprog),
        .i_page_erase(fpage), .i_mass_erase(fmass), .o_rdata(frdata));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // The leading edge keeps two requests from touching cyc in one step.
    task automatic xfer(input logic w, input logic [11:0] idx,
                        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) begin
            check({31'h0, ack}, 32'h1);
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d, junk);
    endtask : wr

    task automatic rd(input logic [11:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0, q);
        check(q, e);
    endtask : rd

    task automatic unlock(input logic [7:0] p1, input logic [7:0] p2);
        wr(`IDX_PAGE_SELECT, {24'h0, p1});
        wr(`IDX_COMMAND, {24'h0, `CMD_UNLOCK_FIRST});
        wr(`IDX_COMMAND, {24'h0, `CMD_UNLOCK_SECOND});
        wr(`IDX_PAGE_SELECT, {24'h0, p2});
    endtask : unlock

    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        wr(`IDX_PROG_ADDR, {16'h0, a});
        wr(`IDX_PROG_DATA, {24'h0, d});
    endtask : prog

    task automatic sector(input logic w, input logic [7:0] v);
        wr(`IDX_COMMAND, {24'h0, `CMD_UNLOCK_FIRST});
        wr(`IDX_COMMAND, {24'h0, `CMD_SECTOR_ACCESS});
        xfer(w, `IDX_PAGE_SELECT, {24'h0, v}, q);
        if (!w) begin
            check(q, {24'h0, v});
        end
        wr(`IDX_COMMAND, 32'h0);
    endtask : sector

    task automatic mem_is(input logic [12:0] a, input logic [7:0] e);
        check({24'h0, far_array.mem[a]}, {24'h0, e});
    endtask : mem_is

    // Exp is the operation time in microseconds; zero means no operation
    // may start. The tick phase runs free, so up to one tick may be lost.
    task automatic op_span(input int exp);
        int cnt, lead;
        cnt = 0;
        lead = 0;
        while (hold !== 1'b1 && lead < 4) begin
            @(posedge clock);
            lead++;
        end
        while (hold === 1'b1 && cnt < 1000) begin
            @(posedge clock);
            cnt++;
        end
        if (exp == 0) begin
            check(cnt, 0);
        end else begin
            check(cnt >= exp * CYCLES_PER_US - CYCLES_PER_US - 2
                && cnt <= exp * CYCLES_PER_US + 2, 1);
        end
    endtask : op_span

    task automatic s_reset();
        rd(`IDX_COMMAND, {26'h0, `STAT_LOCKED});
        check({28'h0, hold, fprog, fpage, fmass}, 32'h0);
        sector(1'b0, 8'h00);
        wr(`IDX_CLOCK_KHZ_HI, 32'h4E);
        wr(`IDX_CLOCK_KHZ_LO, 32'h20);
        rd(`IDX_CLOCK_KHZ_HI, 32'h4E);
        rd(`IDX_CLOCK_KHZ_LO, 32'h20);
        rd(12'h100, 32'h0);
    endtask : s_reset

    task automatic s_program_erase();
        wprot <= 1'b1;
        wr(`IDX_PAGE_SELECT, 32'h2);
        wr(`IDX_COMMAND, {24'h0, `CMD_UNLOCK_FIRST});
        rd(`IDX_COMMAND, {26'h0, `STAT_FIRST});
        wr(`IDX_COMMAND, {24'h0, `CMD_UNLOCK_SECOND});
        rd(`IDX_COMMAND, {26'h0, `STAT_SECOND});
        wr(`IDX_PAGE_SELECT, 32'h2);
        rd(`IDX_COMMAND, {26'h0, `STAT_UNLOCKED});
        prog(16'h0405, 8'hA5);
        op_span(40);
        mem_is(13'h0405, 8'hA5);
        prog(16'h0405, 8'h5F);
        rd(`IDX_COMMAND, {26'h0, `STAT_PROG});
        op_span(40);
        mem_is(13'h0405, 8'h05);
        rd(`IDX_COMMAND, {26'h0, `STAT_UNLOCKED});
        prog(16'h0410, 8'h0F);
        op_span(40);
        mem_is(13'h0410, 8'h0F);
        prog(16'h0600, 8'h00);
        op_span(0);
        mem_is(13'h0600, 8'hFF);
        wr(`IDX_COMMAND, {24'h0, `CMD_PAGE_ERASE});
        op_span(4);
        mem_is(13'h0405, 8'hFF);
        mem_is(13'h0410, 8'hFF);
        rd(`IDX_COMMAND, {26'h0, `STAT_LOCKED});
    endtask : s_program_erase

    task automatic s_refusals();
        unlock(8'h3, 8'h4);
        rd(`IDX_COMMAND, {26'h0, `STAT_LOCKED});
        prog(16'h0600, 8'h00);
        op_span(0);
        unlock(8'h3, 8'h3);
        wr(`IDX_COMMAND, 32'h11);
        rd(`IDX_COMMAND, {26'h0, `STAT_LOCKED});
        prog(16'h0610, 8'h00);
        op_span(0);
        unlock(8'h3, 8'h3);
        wr(`IDX_COMMAND, {24'h0, `CMD_MASS_ERASE});
        op_span(0);
        rd(`IDX_COMMAND, {26'h0, `STAT_LOCKED});
        mem_is(13'h0600, 8'hFF);
    endtask : s_refusals

    task automatic s_sector();
        wr(`IDX_COMMAND, {24'h0, `CMD_UNLOCK_FIRST});
        wr(`IDX_COMMAND, {24'h0, `CMD_SECTOR_ACCESS});
        rd(`IDX_COMMAND, {26'h0, `STAT_SECTOR});
        wr(`IDX_COMMAND, 32'h0);
        sector(1'b1, 8'h02);
        sector(1'b1, 8'h00);
        sector(1'b0, 8'h02);
        unlock(8'h2, 8'h2);
        prog(16'h0420, 8'h00);
        op_span(0);
        mem_is(13'h0420, 8'hFF);
        wr(`IDX_COMMAND, 32'h0);
        unlock(8'h2, 8'h2);
        wr(`IDX_COMMAND, {24'h0, `CMD_PAGE_ERASE});
        op_span(0);
    endtask : s_sector

    task automatic s_write_option();
        wprot <= 1'b0;
        hsw <= 1'b0;
        unlock(8'h0, 8'h0);
        prog(16'h0010, 8'h00);
        op_span(0);
        mem_is(13'h0010, 8'hFF);
        wr(`IDX_COMMAND, 32'h0);
        unlock(8'h0, 8'h0);
        wr(`IDX_COMMAND, {24'h0, `CMD_PAGE_ERASE});
        op_span(0);
    endtask : s_write_option

    // Debug access runs with the write option still off and sector 1 set.
    task automatic s_debug();
        dbg <= 1'b1;
        wr(`IDX_PAGE_SELECT, 32'h2);
        wr(`IDX_COMMAND, {24'h0, `CMD_UNLOCK_FIRST});
        wr(`IDX_COMMAND, {24'h0, `CMD_UNLOCK_SECOND});
        rd(`IDX_COMMAND, {26'h0, `STAT_UNLOCKED});
        prog(16'h1000, 8'h3C);
        op_span(40);
        mem_is(13'h1000, 8'h3C);
        prog(16'h0420, 8'h5A);
        op_span(40);
        rd(`IDX_PROG_DATA, 32'h5A);
        rprot <= 1'b1;
        rd(`IDX_PROG_DATA, 32'h0);
        rprot <= 1'b0;
        wr(`IDX_COMMAND, {24'h0, `CMD_MASS_ERASE});
        op_span(6);
        mem_is(13'h1000, 8'hFF);
        mem_is(13'h0420, 8'hFF);
        rd(`IDX_COMMAND, {26'h0, `STAT_LOCKED});
        sector(1'b1, 8'h00);
        sector(1'b0, 8'h00);
        dbg <= 1'b0;
    endtask : s_debug

    initial begin
        reset = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 14'h0000;
        sel = 4'hF;
        wdat = 32'h0000_0000;
        dbg = 1'b0;
        rprot = 1'b0;
        wprot = 1'b0;
        hsw = 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        s_reset();
        s_program_erase();
        s_refusals();
        s_sector();
        s_write_option();
        s_debug();
        summarize();
    end

    initial begin
        #1000000;
        failures++;
        summarize();
    end
endmodule : tb_top
